// file: scan_seq_pkg.sv
/*
 * Constants, carrier types and states for the scan line sequencer.
 * Assumes a 10 MHz clock; all other files import this package.
 */
package scan_seq_pkg;

    // =========================================================
    // Sizes
    localparam int VEC_W = 7;
    localparam int NUM_VECTORS = 128;
    localparam int LINE_W = 8;
    localparam int TX_W = 16;
    localparam int BF_W = 16;
    localparam int NUM_BF = 3;
    localparam int BF_IDX_W = 2;
    localparam int SAMPLE_W = 11;
    localparam int SAMPLE_ADDR_W = 10;
    localparam int ADDR_W = VEC_W + SAMPLE_ADDR_W;

    // =========================================================
    // Limits per sweep and per line
    localparam logic [LINE_W-1:0] MAX_TISSUE_LINES = 8'h80;
    localparam logic [LINE_W-1:0] MAX_FLOW_LINES = 8'h40;
    localparam logic [SAMPLE_W-1:0] MAX_TISSUE_SAMPLES = 11'h400;
    localparam logic [SAMPLE_W-1:0] MAX_FLOW_SAMPLES = 11'h100;
    localparam logic [BF_IDX_W-1:0] LAST_BF = 2'h2;

    // =========================================================
    // Timing
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int FIRE_TIME_NS = 200;
    localparam int FIRE_CYCLES_INT = (FIRE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
    localparam logic [SAMPLE_W-1:0] FIRE_CYCLES = SAMPLE_W'(FIRE_CYCLES_INT);

    // =========================================================
    // Reset values
    localparam logic [4:0] MOTION_IDLE = 5'h1f;

    // =========================================================
    // Carriers
    typedef struct packed {
        logic tissue_req_n;
        logic flow_req_n;
        logic leftward_n;
        logic rightward_n;
        logic stationary_n;
    } motion_t;

    typedef struct packed {
        logic valid;
        logic to_focus;
        logic [BF_IDX_W-1:0] bf_index;
        logic [VEC_W-1:0] vector;
        logic [TX_W-1:0] data;
    } param_bus_t;

    typedef struct packed {
        logic start;
        logic [VEC_W-1:0] vector;
        logic [ADDR_W-1:0] start_addr;
    } rf_cmd_t;

    typedef struct packed {
        logic valid;
        logic [VEC_W-1:0] vector;
        logic [TX_W-1:0] tx;
        logic [NUM_BF*BF_W-1:0] bf;
    } param_set_t;

    typedef enum {
        ST_IDLE,
        ST_WAIT_REQ,
        ST_LOAD_TX,
        ST_LOAD_BF,
        ST_ARM_RF,
        ST_FIRE,
        ST_SYNC,
        ST_LISTEN,
        ST_LINE_END
    } seq_state_t;

endpackage : scan_seq_pkg

// file: motion_sync.sv
/*
 * Three-stage synchroniser for the motor controller signals.
 * Assumes asynchronous inputs; a change is taken once stages two and three agree.
 */
`timescale 1ns/1ps
module motion_sync
(
    input wire logic clock, // System clock
    input wire logic rstn, // Synchronous reset
    input wire logic clk_en, // Freezes state when low
    input wire scan_seq_pkg::motion_t async_in, // Raw motor signals
    output scan_seq_pkg::motion_t stable_out // Filtered motor signals
);
    import scan_seq_pkg::*;

    motion_t s1_reg, s2_reg, s3_reg, out_reg;
    motion_t s1_next, s2_next, s3_next, out_next;

    // =========================================================
    // Agreement filter per bit
    genvar i;
    generate
        for (i = 0; i < $bits(motion_t); i++)
        begin : g_bit
            always_comb
            begin
                out_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : out_reg[i];
            end
        end
    endgenerate

    always_comb
    begin
        s1_next = async_in;
        s2_next = s1_reg;
        s3_next = s2_reg;
    end

    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            s1_reg <= MOTION_IDLE;
            s2_reg <= MOTION_IDLE;
            s3_reg <= MOTION_IDLE;
            out_reg <= MOTION_IDLE;
        end
        else if (clk_en)
        begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            s3_reg <= s3_next;
            out_reg <= out_next;
        end
    end

    assign stable_out = out_reg;

endmodule : motion_sync

// file: scan_line_sequencer.sv
/*
 * Scan line sequencer: parameter caches, scan program and per-vector
 * load, arm, fire, sync and end-of-line sequence.
 * Assumes a 10 MHz clock, a preload source for caches and program, and
 * a motor controller driving the active-low sweep and request lines.
 */
`timescale 1ns/1ps
// Operation
// - Fill both caches before scan may start
// - Load vector transmit parameters into pulse generators
// - Then load vector focusing parameters
// - Then arm data unit at start address
// - Fire strobe, sync strobe, then line end
// - Next vector loads only after line end
// - Parameter bus idle while listening
// - Parallel option loads three steering sets
// - Tissue request pulse starts firing, 128 max
// - Tissue sweep 128 lines, 1024 samples max
// - Flow lines hold at most 256 samples
module scan_line_sequencer
(
    input wire logic clock, // System clock
    input wire logic rstn, // Synchronous reset
    input wire logic clk_en, // Freezes state when low
    input wire scan_seq_pkg::param_set_t preload, // Cache preload word
    input wire logic prog_we, // Scan program write
    input wire logic [scan_seq_pkg::VEC_W-1:0] prog_addr, // Program slot
    input wire logic [scan_seq_pkg::VEC_W-1:0] prog_vector, // Vector for slot
    input wire logic scan_start, // Start scan program
    input wire logic scan_stop, // Abort scan
    input wire logic [scan_seq_pkg::LINE_W-1:0] lines_per_sweep, // Program length
    input wire logic [scan_seq_pkg::SAMPLE_W-1:0] samples_per_line, // Line depth
    input wire logic flow_mode, // Colour flow acquisition
    input wire logic swept_probe, // Mechanically swept probe
    input wire logic parallel_line_option, // Three beamformers fitted
    input wire scan_seq_pkg::motion_t motion_in, // Motor controller lines
    output scan_seq_pkg::param_bus_t front_end_param_bus, // Parameter bus
    output scan_seq_pkg::rf_cmd_t rf_cmd, // Data unit command
    output logic fire_strobe_n, // Transmit fire, active low
    output logic rx_sync, // Receive sync strobe
    output logic line_end_n, // End of line, active low
    output logic caches_ready, // All parameter sets loaded
    output logic scan_busy, // Scan program running
    output logic [2:0] sweep_state // Leftward, rightward, stationary
);
    import scan_seq_pkg::*;
    // =========================================================
    // Clipping helpers
    function automatic logic [SAMPLE_W-1:0] clip_samples
        (input logic [SAMPLE_W-1:0] req, input logic flow);
        logic [SAMPLE_W-1:0] lim;
        lim = flow ? MAX_FLOW_SAMPLES : MAX_TISSUE_SAMPLES;
        clip_samples = (req > lim || req == '0) ? lim : req;
    endfunction : clip_samples
    function automatic logic [LINE_W-1:0] clip_lines
        (input logic [LINE_W-1:0] req, input logic flow);
        logic [LINE_W-1:0] lim;
        lim = flow ? MAX_FLOW_LINES : MAX_TISSUE_LINES;
        clip_lines = (req > lim) ? lim : req;
    endfunction : clip_lines
    // =========================================================
    // Caches and program
    logic [TX_W-1:0] tx_cache [NUM_VECTORS];
    logic [NUM_BF*BF_W-1:0] bf_cache [NUM_VECTORS];
    logic [VEC_W-1:0] program_mem [NUM_VECTORS];
    logic [NUM_VECTORS-1:0] loaded_reg, loaded_next;
    seq_state_t state_reg, state_next;
    logic [LINE_W-1:0] line_reg, line_next;
    logic [LINE_W-1:0] total_reg, total_next;
    logic [SAMPLE_W-1:0] count_reg, count_next;
    logic [SAMPLE_W-1:0] limit_reg, limit_next;
    logic [BF_IDX_W-1:0] bf_idx_reg, bf_idx_next;
    logic flow_reg, flow_next, multi_reg, multi_next, swept_reg, swept_next;
    logic req_prev_reg, req_prev_next;
    param_bus_t bus_reg, bus_next;
    rf_cmd_t rf_reg, rf_next;
    logic fire_n_reg, fire_n_next, sync_reg, sync_next, eol_n_reg, eol_n_next;
    logic busy_reg, busy_next;
    logic ready_reg, ready_next;
    logic [2:0] sweep_reg, sweep_next;
    motion_t motion;
    logic [VEC_W-1:0] cur_vec;
    logic req_now, req_fall, preload_ok;
    motion_sync u_motion_sync
    (
        .clock(clock),
        .rstn(rstn),
        .clk_en(clk_en),
        .async_in(motion_in),
        .stable_out(motion)
    );
    assign cur_vec = program_mem[line_reg[VEC_W-1:0]];
    assign req_now = flow_reg ? motion.flow_req_n : motion.tissue_req_n;
    assign req_fall = req_prev_reg && !req_now;
    assign preload_ok = preload.valid && !busy_reg;
    // =========================================================
    // Cache bookkeeping and status
    always_comb
    begin
        loaded_next = loaded_reg;
        if (preload_ok)
        begin
            loaded_next[preload.vector] = 1'b1;
        end
        ready_next = &loaded_reg;
        req_prev_next = req_now;
        sweep_next = {!motion.leftward_n, !motion.rightward_n, !motion.stationary_n};
    end
    // =========================================================
    // Per-vector sequence
    always_comb
    begin
        state_next = state_reg;
        line_next = line_reg;
        total_next = total_reg;
        count_next = count_reg;
        limit_next = limit_reg;
        bf_idx_next = bf_idx_reg;
        flow_next = flow_reg;
        multi_next = multi_reg;
        swept_next = swept_reg;
        busy_next = busy_reg;
        bus_next = '0;
        rf_next = '0;
        fire_n_next = 1'b1;
        sync_next = 1'b0;
        eol_n_next = 1'b1;
        case (state_reg)
            ST_IDLE:
            begin
                if (scan_start && ready_reg && lines_per_sweep != '0)
                begin
                    line_next = '0;
                    total_next = clip_lines(lines_per_sweep, flow_mode);
                    limit_next = clip_samples(samples_per_line, flow_mode);
                    flow_next = flow_mode;
                    multi_next = parallel_line_option;
                    swept_next = swept_probe;
                    busy_next = 1'b1;
                    state_next = swept_probe ? ST_WAIT_REQ : ST_LOAD_TX;
                end
            end
            ST_WAIT_REQ:
            begin
                state_next = req_fall ? ST_LOAD_TX : ST_WAIT_REQ;
            end
            ST_LOAD_TX:
            begin
                bus_next = {1'b1, 1'b0, {BF_IDX_W{1'b0}}, cur_vec, tx_cache[cur_vec]};
                bf_idx_next = '0;
                state_next = ST_LOAD_BF;
            end
            ST_LOAD_BF:
            begin
                bus_next = {1'b1, 1'b1, bf_idx_reg, cur_vec,
                    bf_cache[cur_vec][bf_idx_reg*BF_W +: BF_W]};
                if (!multi_reg || bf_idx_reg == LAST_BF)
                begin
                    state_next = ST_ARM_RF;
                end
                else
                begin
                    bf_idx_next = bf_idx_reg + 1'b1;
                end
            end
            ST_ARM_RF:
            begin
                rf_next = {1'b1, cur_vec, cur_vec, {SAMPLE_ADDR_W{1'b0}}};
                count_next = '0;
                state_next = ST_FIRE;
            end
            ST_FIRE:
            begin
                fire_n_next = 1'b0;
                count_next = count_reg + 1'b1;
                if (count_reg == FIRE_CYCLES - 1'b1)
                begin
                    state_next = ST_SYNC;
                end
            end
            ST_SYNC:
            begin
                sync_next = 1'b1;
                count_next = '0;
                state_next = ST_LISTEN;
            end
            ST_LISTEN:
            begin
                count_next = count_reg + 1'b1;
                if (count_reg == limit_reg - 1'b1)
                begin
                    state_next = ST_LINE_END;
                end
            end
            ST_LINE_END:
            begin
                eol_n_next = 1'b0;
                line_next = line_reg + 1'b1;
                if (line_reg + 1'b1 == total_reg)
                begin
                    busy_next = 1'b0;
                    state_next = ST_IDLE;
                end
                else
                begin
                    state_next = swept_reg ? ST_WAIT_REQ : ST_LOAD_TX;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
        if (scan_stop && state_reg != ST_IDLE)
        begin
            state_next = ST_IDLE;
            busy_next = 1'b0;
        end
    end
    // =========================================================
    // Memories
    always_ff @(posedge clock)
    begin
        if (clk_en && preload_ok)
        begin
            tx_cache[preload.vector] <= preload.tx;
            bf_cache[preload.vector] <= preload.bf;
        end
        if (clk_en && prog_we && !busy_reg)
        begin
            program_mem[prog_addr] <= prog_vector;
        end
    end
    // =========================================================
    // State registers
    always_ff @(posedge clock)
    begin
        if (!rstn)
        begin
            loaded_reg <= '0;
            ready_reg <= 1'b0;
            req_prev_reg <= 1'b1;
            sweep_reg <= '0;
            state_reg <= ST_IDLE;
            line_reg <= '0;
            total_reg <= '0;
            count_reg <= '0;
            limit_reg <= '0;
            bf_idx_reg <= '0;
            flow_reg <= 1'b0;
            multi_reg <= 1'b0;
            swept_reg <= 1'b0;
            busy_reg <= 1'b0;
            bus_reg <= '0;
            rf_reg <= '0;
            fire_n_reg <= 1'b1;
            sync_reg <= 1'b0;
            eol_n_reg <= 1'b1;
        end
        else if (clk_en)
        begin
            loaded_reg <= loaded_next;
            ready_reg <= ready_next;
            req_prev_reg <= req_prev_next;
            sweep_reg <= sweep_next;
            state_reg <= state_next;
            line_reg <= line_next;
            total_reg <= total_next;
            count_reg <= count_next;
            limit_reg <= limit_next;
            bf_idx_reg <= bf_idx_next;
            flow_reg <= flow_next;
            multi_reg <= multi_next;
            swept_reg <= swept_next;
            busy_reg <= busy_next;
            bus_reg <= bus_next;
            rf_reg <= rf_next;
            fire_n_reg <= fire_n_next;
            sync_reg <= sync_next;
            eol_n_reg <= eol_n_next;
        end
    end
    assign front_end_param_bus = bus_reg;
    assign rf_cmd = rf_reg;
    assign fire_strobe_n = fire_n_reg;
    assign rx_sync = sync_reg;
    assign line_end_n = eol_n_reg;
    assign caches_ready = ready_reg;
    assign scan_busy = busy_reg;
    assign sweep_state = sweep_reg;
endmodule : scan_line_sequencer

// file: scan_seq_assertions.sv
/*
 * Port checker for scan_line_sequencer, bound after the module.
 * Assumes mode inputs are held steady while a scan runs.
 */
`timescale 1ns/1ps
module scan_seq_assertions
(
    input wire logic clock, // Clock
    input wire logic rstn, // Reset, active low
    input wire logic [scan_seq_pkg::SAMPLE_W-1:0] samples_per_line, // Depth
    input wire logic flow_mode, // Flow mode
    input wire logic swept_probe, // Swept probe
    input wire logic parallel_line_option, // Three beamformers
    input wire scan_seq_pkg::motion_t motion_in, // Motor lines
    input wire scan_seq_pkg::param_bus_t front_end_param_bus, // Bus
    input wire scan_seq_pkg::rf_cmd_t rf_cmd, // Data unit command
    input wire logic fire_strobe_n, // Fire
    input wire logic rx_sync, // Sync
    input wire logic line_end_n, // Line end
    input wire logic caches_ready, // Caches full
    input wire logic scan_busy, // Running
    input wire logic [2:0] sweep_state // Direction
);
    import scan_seq_pkg::*;
    param_bus_t b;
    logic [11:0] cnt_reg, cnt_next;
    logic listen_reg, listen_next;
    logic [SAMPLE_W-1:0] top, lim;
    // ==========================================================
    // Listen window and line depth
    assign b = front_end_param_bus;
    assign top = flow_mode ? MAX_FLOW_SAMPLES : MAX_TISSUE_SAMPLES;
    assign lim = (samples_per_line == 11'h0 || samples_per_line > top) ? top : samples_per_line;
    always_comb
    begin
        cnt_next = rx_sync ? 12'h1 : cnt_reg + 12'h1;
        listen_next = rx_sync | (listen_reg & line_end_n & scan_busy);
    end
    always_ff @(posedge clock)
    begin
        cnt_reg <= rstn ? cnt_next : 12'h0;
        listen_reg <= rstn & listen_next;
    end
    // ==========================================================
    // Properties
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    AST_NO_START_UNREADY: assert property (!caches_ready && !scan_busy |=> !scan_busy)
        else $error("scan started before caches ready");
    AST_FIRST_TX: assert property ($rose(scan_busy) && !swept_probe |=> b.valid && !b.to_focus)
        else $error("no transmit word after start");
    AST_TX_THEN_BF: assert property (b.valid && !b.to_focus |=> b.valid && b.to_focus
        && b.bf_index == 2'h0 && b.vector == $past(b.vector)) else $error("focus word missing");
    AST_BF_THEN_RF: assert property (b.valid && b.to_focus
        && (!parallel_line_option || b.bf_index == LAST_BF) |=> rf_cmd.start)
        else $error("data unit not armed after focus words");
    AST_RF_ADDR: assert property (rf_cmd.start |-> rf_cmd.start_addr == {rf_cmd.vector, 10'h0})
        else $error("bad data unit start address");
    AST_FIRE_SYNC: assert property (rf_cmd.start |=> !fire_strobe_n [*2] ##1 (fire_strobe_n && rx_sync))
        else $error("fire or sync strobe out of place");
    AST_BUS_IDLE: assert property (listen_reg |-> !b.valid)
        else $error("bus active while listening");
    AST_LINE_LEN: assert property ($fell(line_end_n) |-> cnt_reg == 12'(lim) + 12'h1)
        else $error("line length wrong");
    AST_WAIT_REQ: assert property ($rose(scan_busy) && swept_probe |=> !b.valid [*3])
        else $error("swept scan did not wait for request");
    AST_LEFT: assert property ($fell(motion_in.leftward_n) |-> ##[1:6] sweep_state[2])
        else $error("leftward state not seen");
    AST_STILL: assert property ($fell(motion_in.stationary_n) |-> ##[1:6] sweep_state[0])
        else $error("stationary state not seen");
endmodule : scan_seq_assertions

bind scan_line_sequencer scan_seq_assertions u_chk (.clock(clock), .rstn(rstn),
    .samples_per_line(samples_per_line), .flow_mode(flow_mode), .swept_probe(swept_probe),
    .parallel_line_option(parallel_line_option), .motion_in(motion_in),
    .front_end_param_bus(front_end_param_bus), .rf_cmd(rf_cmd), .fire_strobe_n(fire_strobe_n),
    .rx_sync(rx_sync), .line_end_n(line_end_n), .caches_ready(caches_ready),
    .scan_busy(scan_busy), .sweep_state(sweep_state));

// file: motor_ctrl_model.sv
/*
 * Motor controller model: sweep direction lines and line requests.
 * Assumes the bench picks the direction and asks for each request.
 */
`timescale 1ns/1ps
module motor_ctrl_model
(
    input wire logic clock, // Clock
    input wire logic [1:0] dir, // 0 left, 1 right, 2 still
    input wire logic req, // Ask for one line request
    input wire logic flow, // Flow request instead of tissue
    output scan_seq_pkg::motion_t motion // Motor lines
);
    import scan_seq_pkg::*;
    int hold;
    int lines;
    logic [1:0] last_dir;
    initial
    begin
        motion = MOTION_IDLE;
        hold = 0;
        lines = 0;
        last_dir = 2'h2;
    end
    always @(posedge clock)
    begin
        if (dir !== last_dir)
            lines = 0;
        last_dir = dir;
        if (req && lines < (flow ? 64 : 128))
        begin
            hold = 6;
            lines = lines + 1;
        end
        else if (hold > 0)
            hold = hold - 1;
        motion.leftward_n <= !(dir == 2'h0);
        motion.rightward_n <= !(dir == 2'h1);
        motion.stationary_n <= !(dir == 2'h2);
        motion.tissue_req_n <= !(hold > 0 && !flow);
        motion.flow_req_n <= !(hold > 0 && flow);
    end
endmodule : motor_ctrl_model

// file: ultrasound_scan_line_sequencer_bench.sv
/*
 * Bench: preload, program, scans in several modes against a queue model.
 * Assumes the checker is bound to the design.
 */
`timescale 1ns/1ps
module ultrasound_scan_line_sequencer_bench;
    import scan_seq_pkg::*;
    logic clock, rstn, prog_we, scan_start, scan_stop, flow_mode, swept_probe, par, mreq, ce;
    logic fire_n, rx_sync, line_end_n, ready, busy;
    logic [6:0] prog_addr, prog_vector;
    logic [7:0] lines_per_sweep;
    logic [10:0] samples_per_line;
    logic [1:0] dir;
    logic [2:0] sweep;
    param_set_t preload;
    motion_t motion;
    param_bus_t bus;
    rf_cmd_t rf;
    logic [15:0] txm [128];
    logic [47:0] bfm [128];
    logic [6:0] prog [128];
    logic [31:0] got [$];
    logic [31:0] want [$];
    logic [31:0] seed;
    int n_errors, comparisons, cycles, n_ends;
    scan_line_sequencer u_dut (.clock(clock), .rstn(rstn), .clk_en(ce), .preload(preload),
        .prog_we(prog_we), .prog_addr(prog_addr), .prog_vector(prog_vector),
        .scan_start(scan_start), .scan_stop(scan_stop), .lines_per_sweep(lines_per_sweep),
        .samples_per_line(samples_per_line), .flow_mode(flow_mode), .swept_probe(swept_probe),
        .parallel_line_option(par), .motion_in(motion), .front_end_param_bus(bus),
        .rf_cmd(rf), .fire_strobe_n(fire_n), .rx_sync(rx_sync), .line_end_n(line_end_n),
        .caches_ready(ready), .scan_busy(busy), .sweep_state(sweep));
    motor_ctrl_model u_motor (.clock(clock), .dir(dir), .req(mreq), .flow(flow_mode),
        .motion(motion));
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // ==========================================================
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    task automatic check(input logic [31:0] seen, input logic [31:0] exp_v);
        comparisons++;
        if (seen !== exp_v)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, exp_v);
        end
    endtask : check
    task automatic test_done();
        $display("comparisons=%0d n_errors=%0d", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : test_done
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (bus.valid === 1'b1)
            got.push_back({6'h0, bus.to_focus, bus.bf_index, bus.vector, bus.data});
        if (rf.start === 1'b1)
            got.push_back({15'h7fff, rf.start_addr});
        if (line_end_n === 1'b0)
            n_ends <= n_ends + 1;
        if (cycles == 60000)
        begin
            n_errors++;
            test_done();
        end
    end
    // ==========================================================
    // One scan, model built from caches and program
    task automatic run_scan(input int n, input logic [10:0] s, input logic fl, pv, sw);
        int lim, k, j, e0;
        logic [6:0] v;
        lim = fl ? 64 : 128;
        if (n < lim)
            lim = n;
        want.delete();
        for (k = 0; k < lim; k++)
        begin
            v = prog[k];
            want.push_back({6'h0, 3'h0, v, txm[v]});
            for (j = 0; j < (pv ? 3 : 1); j++)
                want.push_back({6'h0, 1'b1, 2'(j), v, bfm[v][16*j +: 16]});
            want.push_back({15'h7fff, v, 10'h0});
        end
        @(posedge clock);
        got.delete();
        e0 = n_ends;
        lines_per_sweep <= 8'(n);
        samples_per_line <= s;
        flow_mode <= fl;
        par <= pv;
        swept_probe <= sw;
        scan_start <= 1'b1;
        @(posedge clock);
        scan_start <= 1'b0;
        @(negedge clock);
        for (k = 0; sw && k < lim; k++)
        begin
            repeat (8) @(posedge clock);
            mreq <= 1'b1;
            @(posedge clock);
            mreq <= 1'b0;
            for (j = 0; j < 3000 && n_ends <= e0 + k; j++)
                @(negedge clock);
        end
        for (k = 0; k < 40000 && busy !== 1'b0; k++)
            @(negedge clock);
        repeat (2) @(posedge clock);
        check(32'(n_ends - e0), 32'(lim));
        check(32'(got.size()), 32'(want.size()));
        foreach (want[i])
            check(got[i], want[i]);
        $display("scan of %0d lines done", lim);
    endtask : run_scan
    // ==========================================================
    // Main sequence
    initial
    begin
        seed = 32'd54921;
        {rstn, prog_we, scan_start, scan_stop, flow_mode, swept_probe, par, mreq} = 8'h0;
        ce = 1'b1;
        preload = '0;
        prog_addr = 7'h0;
        prog_vector = 7'h0;
        lines_per_sweep = 8'h1;
        samples_per_line = 11'h0;
        dir = 2'h2;
        {n_errors, comparisons, cycles, n_ends} = '0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        scan_start <= 1'b1;
        repeat (3) @(posedge clock);
        scan_start <= 1'b0;
        @(negedge clock);
        check(busy, 1'b0);
        check({fire_n, line_end_n, ready}, 3'h6);
        $display("refused start done");
        for (int k = 0; k < 128; k++)
        begin
            @(posedge clock);
            txm[k] = 16'(rnd());
            bfm[k] = 48'({rnd(), rnd()});
            preload <= {1'b1, 7'(k), txm[k], bfm[k]};
            prog[k] = 7'(rnd());
            prog_we <= 1'b1;
            prog_addr <= 7'(k);
            prog_vector <= prog[k];
        end
        @(negedge clock);
        check(ready, 1'b0);
        @(posedge clock);
        preload.valid <= 1'b0;
        prog_we <= 1'b0;
        repeat (4) @(negedge clock);
        check(ready, 1'b1);
        $display("preload done");
        run_scan(200, 11'h1, 1'b0, 1'b0, 1'b0);
        run_scan(100, 11'h12c, 1'b1, 1'b1, 1'b0);
        dir <= 2'h0;
        run_scan(3, 11'h14, 1'b0, 1'b1, 1'b1);
        check(sweep, 3'h4);
        dir <= 2'h1;
        run_scan(2, 11'h0, 1'b1, 1'b0, 1'b1);
        check(sweep, 3'h2);
        dir <= 2'h2;
        lines_per_sweep <= 8'h5;
        swept_probe <= 1'b0;
        scan_start <= 1'b1;
        @(posedge clock);
        scan_start <= 1'b0;
        repeat (30) @(posedge clock);
        ce <= 1'b0;
        scan_stop <= 1'b1;
        repeat (3) @(posedge clock);
        ce <= 1'b1;
        scan_stop <= 1'b0;
        @(negedge clock);
        check(busy, 1'b1);
        @(posedge clock);
        scan_stop <= 1'b1;
        @(posedge clock);
        scan_stop <= 1'b0;
        repeat (2) @(negedge clock);
        check(busy, 1'b0);
        check(sweep, 3'h1);
        $display("abort done");
        test_done();
    end
endmodule : ultrasound_scan_line_sequencer_bench
